// *** dpx_data_access.v ***
`timescale 1ns/1ps
`include "dpx_defines.vh"
module dpx_data_access #(
    parameter EXPANDED_RAM_DEPTH = `DPX_EXPANDED_RAM_MAX
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset,
    // security byte strap for external-data select
    input  wire        i_hsb_ext,
    // sfr register port
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    // core internal data access
    input  wire [7:0]  i_int_addr,
    input  wire        i_int_indirect,
    input  wire        i_int_stack,
    output wire        o_sel_lower,
    output wire        o_sel_upper,
    output wire        o_sel_sfr,
    // core pointer increment; loads come through the sfr register port
    input  wire        i_ptr_inc,
    // core external move request
    input  wire        i_mx_req,
    input  wire        i_mx_write,
    input  wire        i_mx_use_ptr,
    input  wire [7:0]  i_mx_ri,
    input  wire [7:0]  i_mx_wdata,
    output reg         o_mx_done,
    output reg  [7:0]  o_mx_rdata,
    output wire        o_mx_busy,
    // code fetch mapping
    input  wire [15:0] i_code_addr,
    output wire        o_boot_sel,
    // external bus pins
    input  wire [7:0]  i_p0,
    output reg  [7:0]  o_p0,
    output reg         o_p0_oe,
    output reg  [7:0]  o_p2,
    output reg         o_p2_oe,
    output reg         o_ale,
    output reg         o_rd_n,
    output reg         o_wr_n,
    // current pointer for observation
    output wire [15:0] o_ptr
);
    // one-hot sequencer states; a bus move walks address, strobe and end phases
    localparam S_IDLE = 4'b0001;
    localparam S_ADDR = 4'b0010;
    localparam S_STRB = 4'b0100;
    localparam S_END  = 4'b1000;
    // strobe counter reload values; the counter runs down to zero on the last low clock
    localparam integer STRB_SHORT_LAST = `DPX_STROBE_SHORT - 1;
    localparam integer STRB_LONG_LAST  = `DPX_STROBE_LONG - 1;

    // pointer pair and its select
    reg  [15:0] ptr0;
    reg  [15:0] ptr1;
    reg         psel;

    // control bits of both aux registers
    reg         boot_en;
    reg         uflag;
    reg         ext_sel;
    reg  [2:0]  xrs;
    reg         stretch;
    reg         hsb_taken;

    // bus sequencer and strobe length counter
    reg  [3:0]  state;
    reg  [4:0]  cnt;

    // on-chip expanded ram; no reset, contents are undefined after power-up
    reg  [7:0]  expanded_ram [0:EXPANDED_RAM_DEPTH-1];

    // decoded addresses and read views
    wire [15:0] cur_ptr;
    wire [15:0] mx_addr;
    wire        hit_expanded_ram;
    wire [7:0]  aux1_rd;
    wire [7:0]  aux0_rd;
    wire [15:0] next_ptr;
    wire        wr_aux1;
    wire        wr_aux0;
    wire        wr_ptr_lo;
    wire        wr_ptr_hi;

    // enabled expanded_ram size per size field
    function [11:0] expanded_ram_size;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    expanded_ram_size = 12'h100;
                3'h1:    expanded_ram_size = 12'h200;
                3'h2:    expanded_ram_size = 12'h300;
                3'h3:    expanded_ram_size = 12'h400;
                3'h4:    expanded_ram_size = 12'h700;
                default: expanded_ram_size = 12'h700;
            endcase
        end
    endfunction

    // select is read live so the next pointer instruction sees it
    assign cur_ptr = psel ? ptr1 : ptr0;
    assign o_ptr   = cur_ptr;
    // 8-bit moves carry only the low byte
    assign mx_addr = i_mx_use_ptr ? cur_ptr : {8'h00, i_mx_ri};
    assign hit_expanded_ram = !ext_sel && (mx_addr < {4'h0, expanded_ram_size(xrs)});
    assign o_boot_sel = boot_en && (i_code_addr >= `DPX_BOOT_BASE);
    // stack goes to internal ram like an indirect access
    assign o_sel_lower = !i_int_addr[7];
    assign o_sel_upper = i_int_addr[7] && (i_int_indirect || i_int_stack);
    assign o_sel_sfr   = i_int_addr[7] && !i_int_indirect && !i_int_stack;
    assign o_mx_busy = (state != S_IDLE);
    // reserved bits read zero; aux1 bit 2 is never stored
    assign aux1_rd = {2'b00, boot_en, 1'b0, uflag, 1'b0, 1'b0, psel};
    assign aux0_rd = {2'b00, stretch, xrs, ext_sel, 1'b0};

    // register write decodes, shared by the control and pointer processes
    assign wr_aux1   = i_wr && (i_addr == `DPX_ADDR_AUX1);
    assign wr_aux0   = i_wr && (i_addr == `DPX_ADDR_AUX0);
    assign wr_ptr_lo = i_wr && (i_addr == `DPX_ADDR_DPL0);
    assign wr_ptr_hi = i_wr && (i_addr == `DPX_ADDR_DPH0);
    // the increment follows the live select, so a toggle just before it counts
    assign next_ptr  = cur_ptr + 16'h0001;

    // control registers; the flag only stores, nothing reads it in hardware
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            psel    <= 1'b0;
            boot_en <= 1'b0;
            uflag   <= 1'b0;
            xrs     <= `DPX_XRS_RST;
            stretch <= 1'b0;
        end else if (wr_aux1) begin
            psel    <= i_wdata[`DPX_A1_PSEL];
            boot_en <= i_wdata[`DPX_A1_BOOT];
            uflag   <= i_wdata[`DPX_A1_FLAG];
        end else if (wr_aux0) begin
            xrs     <= i_wdata[`DPX_A0_XRS_HI:`DPX_A0_XRS_LO];
            stretch <= i_wdata[`DPX_A0_STRETCH];
        end
    end

    // strap caught in the first clock after reset release, then writable
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ext_sel   <= 1'b0;
            hsb_taken <= 1'b0;
        end else if (!hsb_taken) begin
            ext_sel   <= i_hsb_ext;
            hsb_taken <= 1'b1;
        end else if (wr_aux0) begin
            ext_sel   <= i_wdata[`DPX_A0_EXT];
        end
    end

    // two pointers; only the selected one is loaded or incremented
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ptr0 <= 16'h0000;
            ptr1 <= 16'h0000;
        end else if (wr_ptr_lo) begin
            if (psel) begin
                ptr1[7:0] <= i_wdata;
            end else begin
                ptr0[7:0] <= i_wdata;
            end
        end else if (wr_ptr_hi) begin
            if (psel) begin
                ptr1[15:8] <= i_wdata;
            end else begin
                ptr0[15:8] <= i_wdata;
            end
        end else if (i_ptr_inc) begin
            // a byte write outranks the increment in the same cycle
            if (psel) begin
                ptr1 <= next_ptr;
            end else begin
                ptr0 <= next_ptr;
            end
        end
    end

    // register read data one cycle after the strobe
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `DPX_ADDR_AUX1: o_rdata <= aux1_rd;
                `DPX_ADDR_AUX0: o_rdata <= aux0_rd;
                `DPX_ADDR_DPL0: o_rdata <= cur_ptr[7:0];
                `DPX_ADDR_DPH0: o_rdata <= cur_ptr[15:8];
                default:        o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // on-chip expanded_ram write; no pin moves on this path
    always @(posedge i_clk) begin
        if (state == S_IDLE && i_mx_req && hit_expanded_ram && i_mx_write) begin
            expanded_ram[mx_addr[10:0]] <= i_mx_wdata;
        end
    end

    // external move sequencer; expanded_ram hits finish in one cycle
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state      <= S_IDLE;
            cnt        <= 5'd0;
            o_mx_done  <= 1'b0;
            o_mx_rdata <= 8'h00;
            o_p0       <= 8'h00;
            o_p0_oe    <= 1'b0;
            o_p2       <= 8'h00;
            o_p2_oe    <= 1'b0;
            o_ale      <= 1'b0;
            o_rd_n     <= 1'b1;
            o_wr_n     <= 1'b1;
        end else begin
            o_mx_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (i_mx_req && hit_expanded_ram) begin
                        // on-chip hit answers next cycle and never touches a pin
                        o_mx_done <= 1'b1;
                        if (!i_mx_write) begin
                            o_mx_rdata <= expanded_ram[mx_addr[10:0]];
                        end
                    end else if (i_mx_req) begin
                        // address phase: low byte on port 0 with ale
                        state   <= S_ADDR;
                        o_p0    <= mx_addr[7:0];
                        o_p0_oe <= 1'b1;
                        o_ale   <= 1'b1;
                        if (i_mx_use_ptr) begin
                            o_p2    <= mx_addr[15:8];
                            o_p2_oe <= 1'b1;
                        end
                    end
                end
                S_ADDR: begin
                    // data phase: port 0 turns to data, strobe low
                    o_ale   <= 1'b0;
                    o_p0    <= i_mx_wdata;
                    o_p0_oe <= i_mx_write;
                    o_rd_n  <= i_mx_write;
                    o_wr_n  <= !i_mx_write;
                    cnt     <= stretch ? STRB_LONG_LAST[4:0] : STRB_SHORT_LAST[4:0];
                    state   <= S_STRB;
                end
                S_STRB: begin
                    if (cnt == 5'd0) begin
                        // sample read data at the strobe's last clock
                        if (!o_rd_n) begin
                            o_mx_rdata <= i_p0;
                        end
                        o_rd_n <= 1'b1;
                        o_wr_n <= 1'b1;
                        state  <= S_END;
                    end else begin
                        cnt <= cnt - 5'd1;
                    end
                end
                S_END: begin
                    // port 2 keeps its last address like the classic bus
                    o_p0_oe   <= 1'b0;
                    o_mx_done <= 1'b1;
                    state     <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // dpx_data_access

// *** dpx_defines.vh ***
`ifndef DPX_DEFINES_VH
`define DPX_DEFINES_VH
// register addresses (sfr space)
`define DPX_ADDR_AUX1      8'hA2
`define DPX_ADDR_AUX0      8'h8E
`define DPX_ADDR_DPL0      8'h82
`define DPX_ADDR_DPH0      8'h83
// aux_control_one fields
`define DPX_A1_PSEL        0
`define DPX_A1_FLAG        3
`define DPX_A1_BOOT        5
// aux_control_zero fields
`define DPX_A0_EXT         1
`define DPX_A0_XRS_LO      2
`define DPX_A0_XRS_HI      4
`define DPX_A0_STRETCH     5
// reset values
`define DPX_AUX1_RST       8'h00
`define DPX_AUX0_RST       8'h08
`define DPX_XRS_RST        3'h2
// strobe lengths in clock periods
`define DPX_STROBE_SHORT   6
`define DPX_STROBE_LONG    30
// boot rom window base
`define DPX_BOOT_BASE      16'hF800
// expanded_ram sizes in bytes
`define DPX_EXPANDED_RAM_MAX       1792
`endif

// *** dpx_data_access_props.sv ***
`timescale 1ns/1ps
// pin-level checks of the data access block
module dpx_data_access_props (
    input wire        i_clk,
    input wire        i_reset,
    input wire [7:0]  i_addr,
    input wire        i_rd,
    input wire [7:0]  o_rdata,
    input wire [7:0]  i_int_addr,
    input wire        i_int_indirect,
    input wire        i_int_stack,
    input wire        o_sel_lower,
    input wire        o_sel_upper,
    input wire        o_sel_sfr,
    input wire        i_mx_write,
    input wire        o_mx_done,
    input wire        o_mx_busy,
    input wire [15:0] i_code_addr,
    input wire        o_boot_sel,
    input wire        o_p0_oe,
    input wire        o_ale,
    input wire        o_rd_n,
    input wire        o_wr_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // decode and strobe shape; the strobe length window spans both stretch settings
    AST_LOWER: assert property (!i_int_addr[7] |-> o_sel_lower && !o_sel_upper)
        else $error("lower ram not selected");
    AST_UPPER: assert property (i_int_addr[7] && (i_int_indirect || i_int_stack) |-> o_sel_upper && !o_sel_sfr)
        else $error("upper ram not selected");
    AST_BOOT: assert property (o_boot_sel |-> i_code_addr >= 16'hF800)
        else $error("boot rom below its window");
    AST_AUX_ZERO: assert property ($past(i_rd) && $past(i_addr) == 8'hA2 |-> !o_rdata[2])
        else $error("stuck bit read one");
    AST_STROBE_MIN: assert property ($fell(o_rd_n & o_wr_n) |-> !(o_rd_n & o_wr_n) [*6])
        else $error("strobe too short");
    AST_STROBE_MAX: assert property ($fell(o_rd_n & o_wr_n) |-> ##[6:30] $rose(o_rd_n & o_wr_n))
        else $error("strobe too long");
    AST_QUIET: assert property (!o_mx_busy |-> o_rd_n && o_wr_n)
        else $error("strobe outside bus cycle");
    AST_WR_DIR: assert property (o_mx_busy && !i_mx_write |-> o_wr_n)
        else $error("write strobe on a read");
    AST_WR_DRIVE: assert property (!o_wr_n |-> o_rd_n && o_p0_oe)
        else $error("write strobe without port 0 driven");
    AST_ALE: assert property ($rose(o_ale) |-> o_p0_oe ##1 !o_ale ##1 !(o_rd_n & o_wr_n))
        else $error("address phase malformed");
    AST_DONE: assert property (o_mx_done |=> !o_mx_done)
        else $error("done longer than one cycle");
    C_RD: cover property ($fell(o_rd_n));
    C_WR: cover property ($fell(o_wr_n));
    C_BOOT: cover property (o_boot_sel);
endmodule // dpx_data_access_props
bind dpx_data_access dpx_data_access_props dpx_data_access_props_inst (.*);

// *** dpx_ext_mem.sv ***
`timescale 1ns/1ps
// slow byte memory on the multiplexed bus
module dpx_ext_mem (
    input  wire        i_clk,
    input  wire [7:0]  i_p0,
    input  wire [7:0]  i_p2,
    input  wire        i_ale,
    input  wire        i_rd_n,
    input  wire        i_wr_n,
    output reg  [7:0]  o_din = 8'h00,
    output reg  [15:0] o_adr = 16'h0000
);
    reg [7:0] mem [0:255];
    // only the low byte indexes storage; a released bus toggles so it never looks valid
    always @(posedge i_clk) begin
        if (i_ale)
            o_adr <= {i_p2, i_p0};
        if (!i_wr_n)
            mem[o_adr[7:0]] <= i_p0;
        o_din <= !i_rd_n ? mem[o_adr[7:0]] : ~o_din;
    end
endmodule // dpx_ext_mem

// *** dpx_data_access_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module dpx_data_access_tb_top;
    reg        i_clk = 1'b0, i_reset = 1'b1, i_hsb_ext = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    reg        i_int_indirect = 1'b0, i_int_stack = 1'b0, i_ptr_inc = 1'b0;
    reg        i_mx_req = 1'b0, i_mx_write = 1'b0, i_mx_use_ptr = 1'b0;
    reg  [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_int_addr = 8'h00, i_mx_ri = 8'h00, i_mx_wdata = 8'h00;
    reg [15:0] i_code_addr = 16'h0000, sz;
    wire [7:0] o_rdata, o_mx_rdata, o_p0, o_p2, i_p0, din;
    wire       o_sel_lower, o_sel_upper, o_sel_sfr, o_mx_done, o_mx_busy, o_boot_sel;
    wire       o_p0_oe, o_p2_oe, o_ale, o_rd_n, o_wr_n;
    wire [15:0] o_ptr, ext_adr;
    reg  [7:0] b0, b2;
    reg  [3:0] k;
    int        fail_count = 0, cmp_count = 0, n;
    dpx_data_access dpx_data_access_inst (.*);
    dpx_ext_mem dpx_ext_mem_inst (.i_clk(i_clk), .i_p0(i_p0), .i_p2(o_p2), .i_ale(o_ale),
        .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .o_din(din), .o_adr(ext_adr));
    // port 0 is shared: the block wins while it enables its driver
    assign i_p0 = o_p0_oe ? o_p0 : din;
    // register port cycles
    task wr(input [7:0] a, d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        `CHK(o_rdata, e)
    endtask
    // combinational decode inputs, checked once settled
    task drv(input [15:0] ca, input [7:0] ia, input ind, stk);
        @(posedge i_clk);
        i_code_addr <= ca;
        i_int_addr <= ia;
        i_int_indirect <= ind;
        i_int_stack <= stk;
        @(negedge i_clk);
    endtask
    // one external move; n counts cycles with a strobe low
    task mx(input w, p, input [7:0] ri, wd, input [15:0] ptr);
        wr(8'h82, ptr[7:0]);
        wr(8'h83, ptr[15:8]);
        // pins are sampled settled, before the move can touch them
        @(negedge i_clk);
        b0 = o_p0;
        b2 = o_p2;
        @(posedge i_clk);
        i_mx_write <= w;
        i_mx_use_ptr <= p;
        i_mx_ri <= ri;
        i_mx_wdata <= wd;
        i_mx_req <= 1'b1;
        @(posedge i_clk);
        i_mx_req <= 1'b0;
        n = 0;
        @(negedge i_clk);
        repeat (40) if (o_mx_done !== 1'b1) begin
            n += (o_rd_n & o_wr_n) ? 0 : 1;
            @(negedge i_clk);
        end
        `CHK(o_mx_done, 1'b1)
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial forever #20 i_clk = ~i_clk;
    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_clk);
        rd(8'hA2, 8'h00);
        rd(8'h8E, 8'h08);
        rd(8'h90, 8'h00);
        wr(8'hA2, 8'h2D);
        rd(8'hA2, 8'h29);
        drv(16'hF800, 8'h00, 1'b0, 1'b0);
        `CHK(o_boot_sel, 1'b1)
        drv(16'hF7FF, 8'h00, 1'b0, 1'b0);
        `CHK(o_boot_sel, 1'b0)
        wr(8'hA2, 8'h08);
        drv(16'hF800, 8'h00, 1'b0, 1'b0);
        `CHK(o_boot_sel, 1'b0)
        for (k = 0; k < 12; k++) begin
            drv(16'h0000, {k[1], {7{k[0]}}}, k[2], k[3]);
            `CHK({o_sel_lower, o_sel_upper, o_sel_sfr}, {~k[1], k[1] & (k[2] | k[3]), k[1] & ~k[2] & ~k[3]})
        end
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        wr(8'hA2, 8'h09);
        wr(8'h82, 8'h78);
        wr(8'h83, 8'h56);
        @(negedge i_clk);
        `CHK(o_ptr, 16'h5678)
        wr(8'hA2, 8'h08);
        @(negedge i_clk);
        `CHK(o_ptr, 16'h1234)
        @(posedge i_clk);
        i_ptr_inc <= 1'b1;
        @(posedge i_clk);
        i_ptr_inc <= 1'b0;
        rd(8'h82, 8'h35);
        mx(1'b1, 1'b1, 8'h00, 8'hA5, 16'h0200);
        `CHK({n[7:0], o_p0, o_p2, o_p0_oe}, {8'h00, b0, b2, 1'b0})
        mx(1'b1, 1'b0, 8'h10, 8'h3C, 16'h0200);
        mx(1'b0, 1'b1, 8'h00, 8'h00, 16'h0010);
        `CHK({n[7:0], o_mx_rdata}, {8'h00, 8'h3C})
        mx(1'b0, 1'b1, 8'h00, 8'h00, 16'h0200);
        `CHK(o_mx_rdata, 8'hA5)
        for (k = 0; k < 5; k++) begin
            wr(8'h8E, {3'b000, k[2:0], 2'b00});
            sz = (k == 4) ? 16'd1792 : 16'd256 * (k + 1);
            mx(1'b0, 1'b1, 8'h00, 8'h00, sz - 16'h0001);
            `CHK(n, 0)
            mx(1'b0, 1'b1, 8'h00, 8'h00, sz);
            `CHK(n, 6)
        end
        mx(1'b1, 1'b1, 8'h00, 8'h5A, 16'h0733);
        `CHK({o_p2_oe, ext_adr}, {1'b1, 16'h0733})
        mx(1'b0, 1'b1, 8'h00, 8'h00, 16'h0733);
        `CHK({n[7:0], o_mx_rdata}, {8'h06, 8'h5A})
        wr(8'h8E, 8'h30);
        mx(1'b0, 1'b1, 8'h00, 8'h00, 16'h0733);
        `CHK({n[7:0], o_mx_rdata}, {8'h1E, 8'h5A})
        wr(8'h8E, 8'h0A);
        mx(1'b1, 1'b0, 8'h33, 8'hC3, 16'h0000);
        `CHK({n[7:0], o_p2, ext_adr[7:0], o_p0_oe}, {8'h06, b2, 8'h33, 1'b0})
        mx(1'b0, 1'b0, 8'h33, 8'h00, 16'h0000);
        `CHK(o_mx_rdata, 8'hC3)
        // second reset with the strap set: external-data select must come up set
        @(posedge i_clk);
        i_hsb_ext <= 1'b1;
        i_reset <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_clk);
        rd(8'h8E, 8'h0A);
        rd(8'hA2, 8'h00);
        `CHK({o_ptr, o_p0_oe, o_rd_n, o_wr_n}, {16'h0000, 3'b011})
        mx(1'b0, 1'b1, 8'h00, 8'h00, 16'h0033);
        `CHK({n[7:0], o_mx_rdata}, {8'h06, 8'hC3})
        final_report;
    end
endmodule // dpx_data_access_tb_top
